// >>> hw/csg_clock_guard.sv
// Clock source selection and oscillator halt control with AHB-Lite registers
`timescale 1ns/1ps
module csg_clock_guard
	import csg_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             primary_crystal_en,
	output logic             ext_clock_input_en,
	output logic             int_hs_osc_en,
	output logic             sub_osc_en,
	output logic             sub_ext_clock_en,
	output logic             cpu_clk_en,
	output logic             periph_hw_clock_en,
	output logic             cpu_on_main_src,
	output logic             cpu_on_sub_src
);

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	logic       wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic [7:0] mode_sel_reg;
	logic [7:0] main_ctl_reg;
	logic [7:0] cpu_ctl_reg;
	logic [7:0] int_osc_reg;
	logic [7:0] sub_ctl_reg;
	logic       guard_err_reg;
	logic [2:0] div_cnt_reg;
	logic       cpu_clk_en_reg;
	logic       main_osc_halt;
	logic       osc_pin_mode_sel;
	logic       ext_clock_input_sel;
	logic       int_hs_osc_halt;
	logic       main_clock_source_flag;
	logic       cpu_on_sub_clock_flag;
	logic       req;
	logic [7:0] wd;
	logic       bad;

	assign req       = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wd        = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end
		else if (hready)
		begin
			wr_pend_reg <= req && hwrite;
			wr_addr_reg <= haddr[7:0];
		end
	end

	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		unique case (a)
			CSG_MODE_SEL_OFS: rd_mux = mode_sel_reg;
			CSG_MAIN_CTL_OFS: rd_mux = main_ctl_reg;
			CSG_CPU_CTL_OFS:  rd_mux = {cpu_ctl_reg[7:6],
				cpu_on_sub_clock_flag, cpu_ctl_reg[4:0]};
			CSG_INT_OSC_OFS:  rd_mux = int_osc_reg;
			CSG_SUB_CTL_OFS:  rd_mux = sub_ctl_reg;
			CSG_STATUS_OFS:   rd_mux = {7'h00, main_clock_source_flag};
			default:          rd_mux = 8'h00;
		endcase
	endfunction : rd_mux

	// Captured in the address phase so the word stands through the
	// whole data phase without a wait state
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (req && !hwrite)
			hrdata <= (haddr[7:0] == CSG_STATUS_OFS)
				? {23'h0, guard_err_reg, rd_mux(haddr[7:0])}
				: {24'h0, rd_mux(haddr[7:0])};
	end

	// ----------------------------------------------------------------
	// Control registers with ordering interlocks
	// ----------------------------------------------------------------
	assign main_osc_halt       = main_ctl_reg[CSG_MAIN_HALT_BIT];
	assign osc_pin_mode_sel    = mode_sel_reg[CSG_OSC_PIN_BIT];
	assign ext_clock_input_sel = mode_sel_reg[CSG_EXT_CLK_BIT];
	assign int_hs_osc_halt     = int_osc_reg[CSG_INT_HALT_BIT];

	// Guarded writes are dropped and flagged in the status error bit
	// Clearing the main halt with the pins still in port mode would
	// start the oscillator against whatever drives those port lines
	always_comb
	begin
		bad = 1'b0;
		if (wr_pend_reg)
		begin
			unique case (wr_addr_reg)
				CSG_MODE_SEL_OFS: bad = !main_osc_halt
					&& (wd[7:6] != mode_sel_reg[7:6]);
				CSG_MAIN_CTL_OFS: bad = !wd[CSG_MAIN_HALT_BIT]
					&& ((!osc_pin_mode_sel)
					|| (cpu_on_main_src && main_osc_halt));
				CSG_INT_OSC_OFS:  bad = wd[CSG_INT_HALT_BIT]
					&& !main_clock_source_flag
					&& !cpu_on_sub_clock_flag;
				CSG_SUB_CTL_OFS:  bad = cpu_on_sub_clock_flag
					&& (wd[2:0] != sub_ctl_reg[2:0]);
				default:          bad = 1'b0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mode_sel_reg  <= CSG_MODE_SEL_RST;
			main_ctl_reg  <= CSG_MAIN_CTL_RST;
			cpu_ctl_reg   <= CSG_CPU_CTL_RST;
			int_osc_reg   <= CSG_INT_OSC_RST;
			sub_ctl_reg   <= CSG_SUB_CTL_RST;
			guard_err_reg <= 1'b0;
		end
		else if (wr_pend_reg)
		begin
			guard_err_reg <= bad;
			if (!bad)
			begin
				unique case (wr_addr_reg)
					CSG_MODE_SEL_OFS: mode_sel_reg <= wd & 8'hc1;
					CSG_MAIN_CTL_OFS: main_ctl_reg <= wd & 8'h80;
					CSG_CPU_CTL_OFS:  cpu_ctl_reg  <= wd & 8'h51;
					CSG_INT_OSC_OFS:  int_osc_reg  <= wd & 8'h80;
					CSG_SUB_CTL_OFS:  sub_ctl_reg  <= wd & 8'h07;
					default:          guard_err_reg <= 1'b0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Source selection and oscillator enables
	// ----------------------------------------------------------------
	// Main source only when the high-speed clock is actually running
	assign main_clock_source_flag = cpu_ctl_reg[CSG_CPU_MAIN_SEL]
		&& !main_osc_halt && osc_pin_mode_sel;
	assign cpu_on_sub_clock_flag = cpu_ctl_reg[CSG_CPU_SUB_SEL]
		&& sub_ctl_reg[CSG_SUB_START_BIT];

	// Enables are registered so a refused or partial write can never
	// glitch an oscillator or the external clock pin
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			primary_crystal_en <= 1'b0;
			ext_clock_input_en <= 1'b0;
			int_hs_osc_en      <= 1'b1;
			sub_osc_en         <= 1'b0;
			sub_ext_clock_en   <= 1'b0;
			cpu_on_main_src    <= 1'b0;
			cpu_on_sub_src     <= 1'b0;
		end
		else
		begin
			primary_crystal_en <= !main_osc_halt && osc_pin_mode_sel
				&& !ext_clock_input_sel;
			ext_clock_input_en <= !main_osc_halt && osc_pin_mode_sel
				&& ext_clock_input_sel;
			int_hs_osc_en      <= !int_hs_osc_halt;
			sub_osc_en         <= sub_ctl_reg[CSG_SUB_START_BIT]
				&& !sub_ctl_reg[CSG_SUB_EXT_BIT]
				&& sub_ctl_reg[CSG_SUB_PIN_BIT];
			sub_ext_clock_en   <= sub_ctl_reg[CSG_SUB_START_BIT]
				&& sub_ctl_reg[CSG_SUB_EXT_BIT];
			cpu_on_main_src    <= main_clock_source_flag
				&& !cpu_on_sub_clock_flag;
			cpu_on_sub_src     <= cpu_on_sub_clock_flag;
		end
	end

	// ----------------------------------------------------------------
	// CPU clock divider; peripheral clock never divided
	// ----------------------------------------------------------------
	// Only the CPU enable is thinned; the peripheral enable stays high
	// so peripheral timing does not change with the selected ratio
	function automatic logic [2:0] div_sel(input logic [7:0] c);
		div_sel = (c[0] ? 3'h0 : CSG_DIV_MAX);
	endfunction : div_sel

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_cnt_reg    <= 3'h0;
			cpu_clk_en_reg <= 1'b0;
		end
		else if (div_cnt_reg >= div_sel(cpu_ctl_reg))
		begin
			div_cnt_reg    <= 3'h0;
			cpu_clk_en_reg <= 1'b1;
		end
		else
		begin
			div_cnt_reg    <= div_cnt_reg + 3'h1;
			cpu_clk_en_reg <= 1'b0;
		end
	end

	assign cpu_clk_en         = cpu_clk_en_reg;
	assign periph_hw_clock_en = 1'b1;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	AST_HALT_STOPS_MAIN: assert property (main_osc_halt |=>
		!primary_crystal_en && !ext_clock_input_en)
		else $error("main oscillator running while halted");
	AST_SUB_FLAG: assert property (##1 cpu_on_sub_src
		== $past(cpu_on_sub_clock_flag))
		else $error("sub clock flag mismatch");
	AST_MCS_FLAG: assert property ((main_clock_source_flag
		&& !cpu_on_sub_clock_flag) |=> cpu_on_main_src)
		else $error("main source flag not shown");
	AST_PERIPH_UNDIV: assert property (periph_hw_clock_en)
		else $error("peripheral clock divided");
	AST_DIV_GAP: assert property ((cpu_clk_en && !cpu_ctl_reg[0]
		&& $stable(cpu_ctl_reg))
		|=> (!cpu_clk_en || cpu_ctl_reg[0]) [*4])
		else $error("cpu clock divider wrong");
	AST_PIN_GUARD: assert property ((wr_pend_reg
		&& wr_addr_reg == CSG_MODE_SEL_OFS && !main_osc_halt)
		|=> mode_sel_reg[7:6] == $past(mode_sel_reg[7:6]))
		else $error("pin select changed while main running");
	AST_INT_HALT_GUARD: assert property ((wr_pend_reg
		&& wr_addr_reg == CSG_INT_OSC_OFS && !main_clock_source_flag
		&& !cpu_on_sub_clock_flag) |=> !int_hs_osc_halt)
		else $error("internal oscillator halted while in use");
	AST_SUB_GUARD: assert property ((wr_pend_reg
		&& wr_addr_reg == CSG_SUB_CTL_OFS && cpu_on_sub_clock_flag)
		|=> $stable(sub_ctl_reg[2:0]))
		else $error("subsystem select changed while in use");
	AST_PORT_MODE: assert property ((wr_pend_reg
		&& wr_addr_reg == CSG_MAIN_CTL_OFS && !osc_pin_mode_sel)
		|=> main_osc_halt)
		else $error("main halt cleared in port mode");
	AST_RSV_BITS: assert property (cpu_ctl_reg[3:1] == 3'h0
		&& cpu_ctl_reg[7] == 1'b0 && mode_sel_reg[5:1] == 5'h00)
		else $error("reserved bits set");

	// Enables follow the halt and select bits in the next cycle
	AST_CRYSTAL_ON: assert property ((!main_osc_halt
		&& osc_pin_mode_sel && !ext_clock_input_sel)
		|=> primary_crystal_en)
		else $error("crystal not started after halt cleared");
	AST_EXT_PIN_ON: assert property ((!main_osc_halt
		&& osc_pin_mode_sel && ext_clock_input_sel)
		|=> ext_clock_input_en)
		else $error("external clock pin not enabled");
	AST_INT_OSC_OFF: assert property (int_hs_osc_halt
		|=> !int_hs_osc_en)
		else $error("internal oscillator running while halted");
	AST_SUB_EXT_ON: assert property ((sub_ctl_reg[0]
		&& sub_ctl_reg[CSG_SUB_EXT_BIT]) |=> sub_ext_clock_en)
		else $error("subsystem external clock not enabled");

	// Source flags, the CPU enable pulse train and the guard error flag
	AST_MAIN_RUNNING: assert property (cpu_on_main_src
		|-> $past(!main_osc_halt && osc_pin_mode_sel))
		else $error("main source shown while main stopped");
	AST_ONE_SOURCE: assert property (!(cpu_on_main_src
		&& cpu_on_sub_src))
		else $error("both clock sources shown");
	AST_UNDIV_PULSE: assert property (cpu_ctl_reg[0]
		|=> cpu_clk_en)
		else $error("undivided cpu clock pulse missing");
	AST_DIV_PULSE: assert property (!cpu_ctl_reg[0]
		|-> ##[0:5] cpu_clk_en)
		else $error("divided cpu clock pulse missing");
	AST_ERR_FLAG: assert property ((wr_pend_reg && bad)
		|=> guard_err_reg)
		else $error("refused write not flagged");

	COV_DIVIDED: cover property (cpu_clk_en && !cpu_ctl_reg[0]);
	COV_MAIN: cover property (cpu_on_main_src);
	COV_SUB: cover property (cpu_on_sub_src);
	COV_ERR: cover property (guard_err_reg);
	COV_INT_HALT: cover property (int_hs_osc_halt && cpu_on_main_src);

endmodule : csg_clock_guard

// >>> pkg/csg_pkg.sv
// Package of constants for the clock source switch guard block
// Overview of operation
// - Main halt stops crystal or gates external clock
// - Division ratio divides CPU clock only
// - Sub-clock flag shows CPU clock source
// - Main source flag shows high-speed system clock
package csg_pkg;
	localparam logic [7:0] CSG_MODE_SEL_OFS = 8'h00;
	localparam logic [7:0] CSG_MAIN_CTL_OFS = 8'h04;
	localparam logic [7:0] CSG_CPU_CTL_OFS  = 8'h08;
	localparam logic [7:0] CSG_INT_OSC_OFS  = 8'h0c;
	localparam logic [7:0] CSG_SUB_CTL_OFS  = 8'h10;
	localparam logic [7:0] CSG_STATUS_OFS   = 8'h14;
	// Field positions
	localparam int CSG_OSC_PIN_BIT   = 6;
	localparam int CSG_EXT_CLK_BIT   = 7;
	localparam int CSG_MAIN_HALT_BIT = 7;
	localparam int CSG_INT_HALT_BIT  = 7;
	localparam int CSG_CPU_MAIN_SEL  = 4;
	localparam int CSG_CPU_SUB_SEL   = 6;
	localparam int CSG_SUB_FLAG_BIT  = 5;
	localparam int CSG_SUB_START_BIT = 0;
	localparam int CSG_SUB_EXT_BIT   = 1;
	localparam int CSG_SUB_PIN_BIT   = 2;
	localparam int CSG_MCS_BIT       = 0;
	localparam int CSG_ERR_BIT       = 8;
	// Reset values and divider count limit
	localparam logic [7:0] CSG_MODE_SEL_RST = 8'h00;
	localparam logic [7:0] CSG_MAIN_CTL_RST = 8'h80;
	localparam logic [7:0] CSG_CPU_CTL_RST  = 8'h01;
	localparam logic [7:0] CSG_INT_OSC_RST  = 8'h00;
	localparam logic [7:0] CSG_SUB_CTL_RST  = 8'h00;
	localparam logic [2:0] CSG_DIV_MAX      = 3'h4;
endpackage : csg_pkg

// >>> testbench/tb.sv
// Self-checking bench for the clock source switch guard block
`timescale 1ns/1ps
module tb
	import csg_pkg::*;
;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        xtal_en;
	logic        ext_en;
	logic        ihs_en;
	logic        sub_en;
	logic        cpu_en;
	logic        per_en;
	logic        on_main;
	logic        on_sub;
	int          error_cnt;
	int          samples_checked;
	logic [7:0]  d;
	logic        sub_ext_en;
	logic        hresp;

	csg_clock_guard dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .primary_crystal_en(xtal_en),
		.ext_clock_input_en(ext_en), .int_hs_osc_en(ihs_en),
		.sub_osc_en(sub_en), .sub_ext_clock_en(sub_ext_en),
		.cpu_clk_en(cpu_en),
		.periph_hw_clock_en(per_en), .cpu_on_main_src(on_main),
		.cpu_on_sub_src(on_sub));

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] v);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= {24'h000000, v};
		do @(posedge hclk); while (hready !== 1'b1);
	endtask : xfer

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 8'h00);
		chk($sformatf("reg %h", a), e, hrdata);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		xfer(a, 1'b1, v);
		repeat (2) @(posedge hclk);
		#1;
	endtask : wr

	// Counts CPU and peripheral enable pulses over 25 cycles
	task automatic pulses(input int e);
		int c;
		int p;
		c = 0;
		p = 0;
		repeat (25)
		begin
			@(posedge hclk);
			#1;
			c += (cpu_en === 1'b1);
			p += (per_en === 1'b1);
		end
		chk("cpu_clk_en pulses", e, c);
		chk("periph clock pulses", 25, p);
	endtask : pulses

	task automatic results;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	initial
	begin
		#20000;
		error_cnt++;
		results();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		error_cnt = 0;
		samples_checked = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		void'($urandom(32'hfdeccfe7));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rd(CSG_MODE_SEL_OFS, 32'h00);
		rd(CSG_MAIN_CTL_OFS, 32'h80);
		rd(CSG_CPU_CTL_OFS, 32'h01);
		rd(CSG_INT_OSC_OFS, 32'h00);
		rd(CSG_SUB_CTL_OFS, 32'h00);
		rd(CSG_STATUS_OFS, 32'h00);
		rd(8'h18, 32'h00);
		chk("crystal halted", 0, {xtal_en, ext_en, ~ihs_en});
		chk("hresp okay", 0, hresp);
		for (int i = 0; i < 6; i++)
		begin
			d = (i < 2) ? {8{i[0]}} : 8'($urandom);
			wr(CSG_MODE_SEL_OFS, d);
			rd(CSG_MODE_SEL_OFS, {24'h0, d & 8'hc1});
			wr(CSG_CPU_CTL_OFS, d);
			rd(CSG_CPU_CTL_OFS, {24'h0, d & 8'h51});
		end
		wr(CSG_CPU_CTL_OFS, 8'h10);
		pulses(5);
		wr(CSG_CPU_CTL_OFS, 8'h11);
		pulses(25);
		wr(CSG_INT_OSC_OFS, 8'h80);
		rd(CSG_STATUS_OFS, 32'h100);
		chk("internal osc kept", 1, ihs_en);
		wr(CSG_MODE_SEL_OFS, 8'h00);
		wr(CSG_MAIN_CTL_OFS, 8'h00);
		rd(CSG_MAIN_CTL_OFS, 32'h80);
		rd(CSG_STATUS_OFS, 32'h100);
		wr(CSG_MODE_SEL_OFS, 8'h40);
		wr(CSG_MAIN_CTL_OFS, 8'h00);
		chk("crystal on main", 3'b101, {xtal_en, ext_en, on_main});
		rd(CSG_STATUS_OFS, 32'h001);
		wr(CSG_MODE_SEL_OFS, 8'hc0);
		rd(CSG_MODE_SEL_OFS, 32'h40);
		rd(CSG_STATUS_OFS, 32'h101);
		wr(CSG_INT_OSC_OFS, 8'h80);
		chk("internal osc halted", 0, ihs_en);
		wr(CSG_SUB_CTL_OFS, 8'h05);
		wr(CSG_CPU_CTL_OFS, 8'h41);
		chk("sub source", 4'b1010, {sub_en, sub_ext_en, on_sub, on_main});
		rd(CSG_CPU_CTL_OFS, 32'h61);
		rd(CSG_STATUS_OFS, 32'h000);
		wr(CSG_SUB_CTL_OFS, 8'h00);
		rd(CSG_STATUS_OFS, 32'h100);
		chk("sub osc kept", 1, sub_en);
		wr(CSG_MAIN_CTL_OFS, 8'h80);
		wr(CSG_MODE_SEL_OFS, 8'hc0);
		wr(CSG_MAIN_CTL_OFS, 8'h00);
		chk("ext clock on", 2'b01, {xtal_en, ext_en});
		wr(CSG_MAIN_CTL_OFS, 8'h80);
		chk("ext clock gated", 2'b00, {xtal_en, ext_en});
		wr(CSG_CPU_CTL_OFS, 8'h01);
		wr(CSG_SUB_CTL_OFS, 8'h03);
		chk("sub ext clock", 2'b01, {sub_en, sub_ext_en});
		rd(CSG_STATUS_OFS, 32'h000);
		results();
	end
endmodule : tb
